/* File: src/aperture_pkg.sv */
// Constants, types and map layout for the aperture address decoder.
package aperture_pkg;
    localparam int NUM_MASTERS   = 3;
    localparam int NUM_APERTURES = 16;
    localparam int MASTER_TUNNEL = 2;
    localparam logic [3:0]  BRIDGE_APERTURE_RST = 4'hF;
    localparam logic [31:0] CLK_GEN_OFFSET  = 32'h0000_0000;
    localparam logic [31:0] CLK_GEN_SIZE    = 32'h0000_1000;
    localparam logic [31:0] CTRL_REG_OFFSET = 32'h0000_1000;
    localparam logic [31:0] CTRL_REG_SIZE   = 32'h0000_1000;
    localparam logic [31:0] IRQC_OFFSET  = 32'h0000_2000;
    localparam logic [31:0] GPIO_OFFSET  = 32'h0000_3000;
    localparam logic [31:0] UART_OFFSET  = 32'h0000_5000;
    localparam logic [31:0] SMALL_SIZE   = 32'h0000_0080;
    localparam logic [31:0] VECTOR_RST   = 32'h0000_0000;
    localparam logic [31:0] VECTOR_ALIGN_MASK = 32'hFFFF_FC00;
    localparam logic [2:0]  TARGET_RST   = 3'h0;
    localparam logic [3:0]  OFFSET_RST   = 4'h0;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_DDR, TGT_SRAM, TGT_TUNNEL, TGT_APB, TGT_ROM, TGT_COHERENT, TGT_RESERVED
    } target_select_e;

    typedef enum logic [2:0] {
        PER_NONE, PER_CLK_GEN, PER_CTRL_REG, PER_IRQ, PER_GPIO, PER_UART
    } periph_e;

    typedef struct packed {
        logic       valid;
        logic [31:0] addr;
    } request_s;

    typedef struct packed {
        logic           valid;
        target_select_e target;
        logic [31:0]    addr;
        periph_e        periph;
        logic           boot_mirror;
    } route_s;

    typedef struct packed {
        logic [2:0] target_select;
        logic [3:0] target_offset;
        logic       boot_mirror;
    } aperture_cfg_s;
endpackage : aperture_pkg

/* File: src/aperture_address_decoder.sv */
// Per-master aperture address decoder with peripheral sub-map and core start control.
`timescale 1ns/1ps

module aperture_address_decoder (
    input  wire logic                                  CLK_IN,
    input  wire logic                                  RESET_IN,
    input  wire aperture_pkg::request_s                REQ_IN [aperture_pkg::NUM_MASTERS],
    input  wire logic                                  CFG_WE_IN,
    input  wire logic [1:0]                            CFG_MASTER_IN,
    input  wire logic [3:0]                            CFG_APERTURE_IN,
    input  wire aperture_pkg::aperture_cfg_s           CFG_DATA_IN,
    input  wire logic                                  BRIDGE_WE_IN,
    input  wire logic [3:0]                            BRIDGE_APERTURE_IN,
    input  wire logic                                  VECTOR_WE_IN,
    input  wire logic [0:0]                            VECTOR_CORE_IN,
    input  wire logic [31:0]                           VECTOR_DATA_IN,
    input  wire logic [1:0]                            AUTO_START_IN,
    input  wire logic [1:0]                            DEBUG_START_IN,
    input  wire logic [1:0]                            BUTTON_START_IN,
    input  wire logic [1:0]                            SW_START_IN,
    input  wire logic [3:0]                            BOOT_SOURCE_IN,
    output aperture_pkg::route_s                       ROUTE_OUT [aperture_pkg::NUM_MASTERS],
    output logic [1:0]                                 CORE_RUN_OUT,
    output logic [31:0]                                CORE_VECTOR_OUT [2],
    output logic [3:0]                                 BRIDGE_APERTURE_OUT
);
    aperture_pkg::aperture_cfg_s cfg_r [aperture_pkg::NUM_MASTERS][aperture_pkg::NUM_APERTURES];
    aperture_pkg::route_s        route_nxt [aperture_pkg::NUM_MASTERS];
    logic [3:0]                  bridge_ap_r;
    logic [31:0]                 vector_r [2];
    logic [1:0]                  run_r;
    logic [1:0]                  button_meta_r;
    logic [1:0]                  button_sync_r;
    logic [1:0]                  button_prev_r;
    logic                        reset_seen_r;
    logic [1:0]                  start_req;

    // Peripheral window decode inside the bridge segment.
    function automatic aperture_pkg::periph_e periph_decode(input logic [27:0] off);
        logic [31:0] a;
        a = {4'h0, off};
        if (a - aperture_pkg::CLK_GEN_OFFSET < aperture_pkg::CLK_GEN_SIZE)
            periph_decode = aperture_pkg::PER_CLK_GEN;
        else if (a - aperture_pkg::CTRL_REG_OFFSET < aperture_pkg::CTRL_REG_SIZE)
            periph_decode = aperture_pkg::PER_CTRL_REG;
        else if (a - aperture_pkg::IRQC_OFFSET < aperture_pkg::SMALL_SIZE)
            periph_decode = aperture_pkg::PER_IRQ;
        else if (a - aperture_pkg::GPIO_OFFSET < aperture_pkg::SMALL_SIZE)
            periph_decode = aperture_pkg::PER_GPIO;
        else if (a - aperture_pkg::UART_OFFSET < aperture_pkg::SMALL_SIZE)
            periph_decode = aperture_pkg::PER_UART;
        else
            periph_decode = aperture_pkg::PER_NONE;
    endfunction : periph_decode

    always_comb begin
        for (int m = 0; m < aperture_pkg::NUM_MASTERS; m++) begin
            aperture_pkg::aperture_cfg_s c;
            c = cfg_r[m][REQ_IN[m].addr[31:28]];
            route_nxt[m].valid       = REQ_IN[m].valid;
            route_nxt[m].target      = aperture_pkg::target_select_e'(c.target_select);
            route_nxt[m].addr        = {c.target_offset, REQ_IN[m].addr[27:0]};
            route_nxt[m].boot_mirror = c.boot_mirror;
            route_nxt[m].periph      = aperture_pkg::PER_NONE;
            if (c.target_select == aperture_pkg::TGT_APB)
                route_nxt[m].periph = periph_decode(REQ_IN[m].addr[27:0]);
            if (c.boot_mirror) begin
                route_nxt[m].addr[31:28] = BOOT_SOURCE_IN;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            for (int m = 0; m < aperture_pkg::NUM_MASTERS; m++) begin
                for (int a = 0; a < aperture_pkg::NUM_APERTURES; a++) begin
                    cfg_r[m][a] <= '{aperture_pkg::TARGET_RST, aperture_pkg::OFFSET_RST, 1'b0};
                end
                ROUTE_OUT[m] <= '0;
            end
        end else begin
            if (CFG_WE_IN && CFG_MASTER_IN < 2'(aperture_pkg::NUM_MASTERS)) begin
                cfg_r[CFG_MASTER_IN][CFG_APERTURE_IN] <= CFG_DATA_IN;
            end
            ROUTE_OUT <= route_nxt;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            bridge_ap_r <= aperture_pkg::BRIDGE_APERTURE_RST;
            vector_r[0] <= aperture_pkg::VECTOR_RST;
            vector_r[1] <= aperture_pkg::VECTOR_RST;
        end else begin
            if (BRIDGE_WE_IN) begin
                bridge_ap_r <= BRIDGE_APERTURE_IN;
            end
            if (VECTOR_WE_IN) begin
                vector_r[VECTOR_CORE_IN] <= VECTOR_DATA_IN & aperture_pkg::VECTOR_ALIGN_MASK;
            end
        end
    end

    assign BRIDGE_APERTURE_OUT = bridge_ap_r;
    assign CORE_VECTOR_OUT     = vector_r;

    // Start sources; the button is a board pin and is synchronised first.
    assign start_req = DEBUG_START_IN | SW_START_IN | (button_sync_r & ~button_prev_r)
                     | (AUTO_START_IN & {2{reset_seen_r}});

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            run_r         <= 2'h0;
            button_meta_r <= 2'h0;
            button_sync_r <= 2'h0;
            button_prev_r <= 2'h0;
            reset_seen_r  <= 1'b1;
        end else begin
            button_meta_r <= BUTTON_START_IN;
            button_sync_r <= button_meta_r;
            button_prev_r <= button_sync_r;
            reset_seen_r  <= 1'b0;
            run_r         <= run_r | start_req;
        end
    end

    assign CORE_RUN_OUT = run_r;

    a_halt_after_reset: assert property (@(posedge CLK_IN)
        $past(RESET_IN) |-> CORE_RUN_OUT == 2'h0)
        else $error("core running right after reset");

    a_sw_start_core: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        SW_START_IN[0] |=> CORE_RUN_OUT[0])
        else $error("software start did not run core");

    a_run_sticky: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        CORE_RUN_OUT[1] |=> CORE_RUN_OUT[1])
        else $error("core stopped without reset");

    a_vector_aligned: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        $past(VECTOR_WE_IN) && !$past(RESET_IN) && $past(VECTOR_CORE_IN) == 1'b0
        |-> CORE_VECTOR_OUT[0] == ($past(VECTOR_DATA_IN) & 32'hFFFF_FC00))
        else $error("reset vector not 1KB aligned copy");

    a_low_bits_kept: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid |=> ROUTE_OUT[0].addr[27:0] == $past(REQ_IN[0].addr[27:0]))
        else $error("low address bits changed");

    a_tunnel_own_map: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[2].valid |=> ROUTE_OUT[2].target
            == $past(cfg_r[2][REQ_IN[2].addr[31:28]].target_select))
        else $error("tunnel master used wrong map");

    a_offset_upper: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[1].valid && !cfg_r[1][REQ_IN[1].addr[31:28]].boot_mirror
        |=> ROUTE_OUT[1].addr[31:28] == $past(cfg_r[1][REQ_IN[1].addr[31:28]].target_offset))
        else $error("slave address top bits not offset");

    a_ctrl_reg_window: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select == 3'h4
        && REQ_IN[0].addr[27:12] == 16'h0001
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_CTRL_REG)
        else $error("control block window missed");

    a_uart_window: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select == 3'h4
        && REQ_IN[0].addr[27:7] == 21'h0000A0
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_UART)
        else $error("uart window missed");

    a_valid_follows: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        !$past(RESET_IN) |-> ROUTE_OUT[1].valid == $past(REQ_IN[1].valid))
        else $error("route valid does not follow request");

    a_target_code: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[1].valid |=> ROUTE_OUT[1].target
            == $past(cfg_r[1][REQ_IN[1].addr[31:28]].target_select))
        else $error("target code not routed");

    a_tunnel_passthru: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[1].valid && cfg_r[1][REQ_IN[1].addr[31:28]].target_select == 3'h3
        && !cfg_r[1][REQ_IN[1].addr[31:28]].boot_mirror
        |=> ROUTE_OUT[1].addr == {$past(cfg_r[1][REQ_IN[1].addr[31:28]].target_offset),
                                  $past(REQ_IN[1].addr[27:0])})
        else $error("tunnel address altered");

    a_periph_only_apb: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select != 3'h4
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_NONE)
        else $error("peripheral decoded outside bridge segment");

    a_bridge_reset: assert property (@(posedge CLK_IN)
        $past(RESET_IN) |-> BRIDGE_APERTURE_OUT == aperture_pkg::BRIDGE_APERTURE_RST)
        else $error("bridge segment not at top aperture after reset");

    a_clk_gen_window: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select == 3'h4
        && REQ_IN[0].addr[27:12] == 16'h0000
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_CLK_GEN)
        else $error("clock generator window missed");

    a_irq_window: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select == 3'h4
        && REQ_IN[0].addr[27:7] == 21'h000040
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_IRQ)
        else $error("interrupt controller window missed");

    a_gpio_window: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[0].valid && cfg_r[0][REQ_IN[0].addr[31:28]].target_select == 3'h4
        && REQ_IN[0].addr[27:7] == 21'h000060
        |=> ROUTE_OUT[0].periph == aperture_pkg::PER_GPIO)
        else $error("gpio window missed");

    a_mirror_top: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        REQ_IN[1].valid && cfg_r[1][REQ_IN[1].addr[31:28]].boot_mirror
        |=> ROUTE_OUT[1].addr[31:28] == $past(BOOT_SOURCE_IN))
        else $error("boot mirror source not applied");
endmodule : aperture_address_decoder

/* File: verif/master_model.sv */
// Behavioural model of the fabric masters that issue requests to the decoder.
`timescale 1ns/1ps
module master_model (
    input  wire logic              clk_in,
    output aperture_pkg::request_s req_out [aperture_pkg::NUM_MASTERS]
);
    initial begin
        foreach (req_out[i]) req_out[i] = '0;
    end

    // Holds one request for a cycle, then drops valid and scrambles the released address.
    task automatic send(input int m, input logic [31:0] a);
        @(posedge clk_in) #1;
        req_out[m] = '{1'b1, a};
        @(posedge clk_in) #1;
        req_out[m] = '{1'b0, ~a};
    endtask : send
endmodule : master_model

/* File: verif/test_aperture_address_decoder.sv */
// Self-checking testbench for the aperture address decoder.
`timescale 1ns/1ps
module test_aperture_address_decoder;
    logic                        clk, rst, cfg_we, br_we, vec_we;
    logic [1:0]                  cfg_m, auto_st, dbg_st, btn_st, sw_st, run;
    logic [3:0]                  cfg_ap, br_ap, boot_src, br_out;
    logic [0:0]                  vec_core;
    logic [31:0]                 vec_data;
    logic [31:0]                 vec [2];
    aperture_pkg::aperture_cfg_s cfg_d;
    aperture_pkg::request_s      req [aperture_pkg::NUM_MASTERS];
    aperture_pkg::route_s        route [aperture_pkg::NUM_MASTERS];
    int                          n_mismatch = 0;
    int                          cmp_count = 0;

    master_model mm (.clk_in(clk), .req_out(req));
    aperture_address_decoder dut (.CLK_IN(clk), .RESET_IN(rst), .REQ_IN(req), .CFG_WE_IN(cfg_we),
        .CFG_MASTER_IN(cfg_m), .CFG_APERTURE_IN(cfg_ap), .CFG_DATA_IN(cfg_d), .BRIDGE_WE_IN(br_we),
        .BRIDGE_APERTURE_IN(br_ap), .VECTOR_WE_IN(vec_we), .VECTOR_CORE_IN(vec_core),
        .VECTOR_DATA_IN(vec_data), .AUTO_START_IN(auto_st), .DEBUG_START_IN(dbg_st),
        .BUTTON_START_IN(btn_st), .SW_START_IN(sw_st), .BOOT_SOURCE_IN(boot_src), .ROUTE_OUT(route),
        .CORE_RUN_OUT(run), .CORE_VECTOR_OUT(vec), .BRIDGE_APERTURE_OUT(br_out));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_route(input int m, input logic [2:0] t, input logic [31:0] a, input logic [2:0] p,
                             input logic b);
        chk_val(route[m], {1'b1, t, a, p, b});
    endtask : chk_route

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic reset_dut(input logic [1:0] a);
        auto_st = a;
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
    endtask : reset_dut

    task automatic cfg(input logic [1:0] m, input logic [3:0] ap, input logic [2:0] t, input logic [3:0] o,
                       input logic b);
        cfg_m = m;
        cfg_ap = ap;
        cfg_d = '{t, o, b};
        cfg_we = 1'b1;
        step(1);
        cfg_we = 1'b0;
        step(1);
    endtask : cfg

    task automatic t_targets;
        for (int c = 0; c < 8; c++) begin
            cfg(2'h0, 4'(c + 8), 3'(c), 4'(c ^ 5), 1'b0);
            mm.send(0, {4'(c + 8), 28'h0ABC_DEF});
            chk_route(0, 3'(c), {4'(c ^ 5), 28'h0ABC_DEF}, 3'h0, 1'b0);
        end
    endtask : t_targets

    task automatic t_masters;
        cfg(2'h1, 4'hD, 3'h3, 4'hD, 1'b0);
        cfg(2'h2, 4'hD, 3'h1, 4'h3, 1'b0);
        cfg(2'h3, 4'hD, 3'h2, 4'h9, 1'b0);
        mm.send(1, 32'hD123_4567);
        chk_route(1, 3'h3, 32'hD123_4567, 3'h0, 1'b0);
        mm.send(2, 32'hD123_4567);
        chk_route(2, 3'h1, 32'h3123_4567, 3'h0, 1'b0);
        mm.send(0, 32'hD123_4567);
        chk_route(0, 3'h5, 32'h0123_4567, 3'h0, 1'b0);
    endtask : t_masters

    task automatic t_periph;
        logic [15:0] offs [10] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h207F, 16'h2080,
                                   16'h3000, 16'h5000, 16'h5080};
        logic [2:0]  pe [10] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0, 3'h4, 3'h5, 3'h0};
        cfg(2'h0, 4'hF, 3'h4, 4'h0, 1'b0);
        foreach (offs[i]) begin
            mm.send(0, {16'hF000, offs[i]});
            chk_route(0, 3'h4, {16'h0000, offs[i]}, pe[i], 1'b0);
        end
        cfg(2'h0, 4'hE, 3'h4, 4'h0, 1'b0);
        mm.send(0, 32'hE000_3010);
        chk_route(0, 3'h4, 32'h0000_3010, 3'h4, 1'b0);
        cfg(2'h0, 4'hF, 3'h1, 4'h0, 1'b0);
        mm.send(0, 32'hF000_1000);
        chk_route(0, 3'h1, 32'h0000_1000, 3'h0, 1'b0);
        br_ap = 4'hE;
        br_we = 1'b1;
        step(1);
        br_we = 1'b0;
        chk_val(br_out, 4'hE);
    endtask : t_periph

    task automatic t_start;
        reset_dut(2'h0);
        chk_val(run, 2'h0);
        chk_val(vec[0], 32'h0);
        sw_st = 2'h1;
        step(1);
        sw_st = 2'h0;
        chk_val(run, 2'h1);
        dbg_st = 2'h2;
        step(1);
        dbg_st = 2'h0;
        chk_val(run, 2'h3);
        reset_dut(2'h0);
        btn_st = 2'h2;
        step(5);
        btn_st = 2'h0;
        chk_val(run, 2'h2);
        reset_dut(2'h1);
        auto_st = 2'h0;
        chk_val(run, 2'h1);
        vec_core = 1'b1;
        vec_data = 32'h1234_5678;
        vec_we = 1'b1;
        step(1);
        vec_we = 1'b0;
        chk_val(vec[1], 32'h1234_5400);
        step(1);
        vec_core = 1'b0;
        vec_data = 32'hFFFF_FFFF;
        vec_we = 1'b1;
        step(1);
        vec_we = 1'b0;
        chk_val(vec[0], 32'hFFFF_FC00);
        chk_val(vec[1], 32'h1234_5400);
    endtask : t_start

    task automatic t_mirror;
        boot_src = 4'hA;
        cfg(2'h1, 4'h0, 3'h2, 4'h2, 1'b1);
        mm.send(1, 32'h0000_0100);
        chk_route(1, 3'h2, 32'hA000_0100, 3'h0, 1'b1);
    endtask : t_mirror

    initial begin
        #100us;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {cfg_we, br_we, vec_we, cfg_m, auto_st, dbg_st, btn_st, sw_st} = '0;
        {cfg_ap, br_ap, boot_src, vec_core, vec_data} = '0;
        cfg_d = '0;
        step(2);
        rst = 1'b0;
        step(1);
        chk_val(br_out, 4'hF);
        chk_val(run, 2'h0);
        t_targets();
        t_masters();
        t_periph();
        t_start();
        t_mirror();
        give_verdict();
    end
endmodule : test_aperture_address_decoder
